/* core/input_function_pkg.sv */
// Constants, register map and carrier types for the input function decoder
package input_function_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned NUM_TERMS = 8;
	localparam int unsigned ADDR_W = 12;

	// ==========================================================
	// Function codes a terminal may be assigned
	localparam logic [7:0] FN_CANCEL_OPTIMAL = 8'h0d;
	localparam logic [7:0] FN_MOTOR_TWO = 8'h0e;
	localparam logic [7:0] FN_SRC_VOLT1 = 8'h0f;
	localparam logic [7:0] FN_SRC_CURR = 8'h10;
	localparam logic [7:0] FN_SRC_VOLT2 = 8'h11;
	localparam logic [7:0] FN_RAMP_STOP = 8'h12;
	localparam logic [7:0] FN_STEP_UP = 8'h13;
	localparam logic [7:0] FN_STEP_DOWN = 8'h14;
	localparam logic [7:0] FN_PID_OFF = 8'h15;
	localparam logic [7:0] FN_COUNT_CLEAR = 8'h16;
	localparam logic [7:0] FN_COUNT_INPUT = 8'h17;
	localparam logic [7:0] FN_FWD_INCH = 8'h18;
	localparam logic [7:0] FN_REV_INCH = 8'h19;
	localparam logic [7:0] FN_EMERG_FAULT = 8'h1c;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_FUNC_LO = 12'h004;
	localparam logic [11:0] OFS_FUNC_HI = 12'h008;
	localparam logic [11:0] OFS_STEP = 12'h00c;
	localparam logic [11:0] OFS_RATE = 12'h010;
	localparam logic [11:0] OFS_FREQ = 12'h014;
	localparam logic [11:0] OFS_COUNT = 12'h018;
	localparam logic [11:0] OFS_TARGET = 12'h01c;
	localparam logic [11:0] OFS_EVENT = 12'h020;
	localparam logic [11:0] OFS_MASK = 12'h024;
	localparam logic [11:0] OFS_STATE = 12'h028;

	// Control register fields
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_TORQUE = 4;
	localparam int unsigned CTRL_FAULT_RESET = 5;
	localparam int unsigned CTRL_EN_VOLT1 = 8;
	localparam int unsigned CTRL_EN_CURR = 9;
	localparam int unsigned CTRL_EN_VOLT2 = 10;
	localparam int unsigned CTRL_UPDN_SRC = 11;

	// Event bits
	localparam int unsigned EV_TARGET = 0;
	localparam int unsigned EV_FAULT = 1;
	localparam int unsigned EV_RAMP_STOP = 2;
	localparam int unsigned EV_INCH = 3;
	localparam int unsigned EV_W = 4;

	// Reset values and the fault display code
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [15:0] STEP_RESET = 16'h0001;
	localparam logic [31:0] RATE_RESET = 32'h0001_0001;
	localparam logic [7:0] FAULT_DISPLAY = 8'h01;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned HOLD_TIME_MS = 500;
	localparam int unsigned RATE_TIME_MS = 10;
	localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RATE_CYCLES = RATE_TIME_MS * (CLK_HZ / 1000);

	// ==========================================================
	// Types
	typedef logic [NUM_TERMS-1:0][7:0] term_codes_t;

	typedef enum logic [1:0]
	{
		SRC_PARAM = 2'b00,
		SRC_VOLT1 = 2'b01,
		SRC_CURR = 2'b10,
		SRC_VOLT2 = 2'b11
	} freq_src_t;

	typedef enum logic [1:0]
	{
		FLT_NORMAL = 2'b00,
		FLT_ACTIVE = 2'b01,
		FLT_WAIT_RESET = 2'b10
	} fault_state_t;

	typedef struct packed
	{
		logic auto_ramp;
		logic motor_set_two;
		freq_src_t freq_src;
		logic ramp_stop;
		logic coast;
		logic run_enable;
		logic pid_disable;
		logic forward_inch_command;
		logic reverse_inch_command;
		logic torque_mode;
		logic external_fault_flag;
		logic [7:0] emergency_fault_code;
		logic [15:0] freq_cmd;
		logic [15:0] count_value;
		logic count_reached;
	} drive_ctrl_t;

endpackage : input_function_pkg

/* core/input_function_decoder.sv */
// Multi-function input terminal decoder for functions 13 to 28, with APB registers
//
// Contract
// - Function 13 with mode 1..4: off gives automatic ramp, on gives linear.
// - Function 14 on selects motor parameter set two, off set one.
// - Function 15 on, and enabled, selects analog voltage input one.
// - Function 16 on, and enabled, selects the analog current input.
// - Function 17 on, and enabled, selects analog voltage input two.
// - Source priority: voltage one, then current, then voltage two.
// - Function 18 on ramps the output down to stop.
// - Functions 19/20 step the frequency up/down by one step per rising edge.
// - Held up/down keeps changing the frequency at the continuous rate.
// - Function 21 on keeps PID disabled.
// - Function 22 on holds the counter at zero; counting resumes once off.
// - Function 23 adds one per rising edge, compared against the target.
// - Function 24 on runs a forward inch.
// - Function 25 on runs a reverse inch.
// - Inching in torque mode switches to speed mode, then back.
// - Function 28 on: emergency stop, show fault code, coast till terminal normal and reset issued.
// - After that fault, no run until terminal normal and reset issued.
`timescale 1ns/10ps

module input_function_decoder
	import input_function_pkg::*;
#(
	parameter int unsigned HOLD_CYC = HOLD_CYCLES,
	parameter int unsigned RATE_CYC = RATE_CYCLES
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Terminal contacts
	input wire logic [NUM_TERMS-1:0] contact,
	// Drive control outputs
	output drive_ctrl_t drive_ctrl,
	output logic irq
);

	// ==========================================================
	// Helpers
	// True when any terminal assigned to code shows a set bit
	function automatic logic any_term(input logic [NUM_TERMS-1:0] bits,
		input term_codes_t codes, input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_TERMS; i++)
		begin
			if (codes[i] == code && bits[i])
				hit = 1'b1;
		end
		return hit;
	endfunction : any_term

	// Saturating up or down move of the frequency command
	function automatic logic [15:0] move_freq(input logic [15:0] f,
		input logic [15:0] d, input logic up);
		logic [16:0] s;
		s = 17'h00000;
		if (up)
		begin
			s = {1'b0, f} + {1'b0, d};
			return s[16] ? 16'hffff : s[15:0];
		end
		return (f > d) ? (f - d) : 16'h0000;
	endfunction : move_freq

	// ==========================================================
	// Registers and state
	logic [11:0] ctrl;
	term_codes_t codes;
	logic [15:0] step_unit;
	logic [31:0] rate;
	logic [15:0] freq;
	logic [15:0] count;
	logic [15:0] target;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] mask;
	logic [NUM_TERMS-1:0] sampled;
	logic [NUM_TERMS-1:0] prev;
	logic [23:0] hold_cnt;
	logic [23:0] rate_cnt;
	logic holding;
	fault_state_t fault_state;

	logic [NUM_TERMS-1:0] rise;
	logic wr_done;
	logic rd_done;
	logic fault_reset;
	logic lv_cancel, lv_motor, lv_volt1, lv_curr, lv_volt2, lv_stop, lv_up, lv_down;
	logic lv_pid, lv_clear, lv_fwd, lv_rev, lv_fault;
	logic rs_up, rs_down, rs_count, rs_stop;
	logic inch_fwd, inch_rev;
	logic [1:0] mode;
	logic updn_ok;
	logic count_inc;
	logic [EV_W-1:0] new_events;
	logic [31:0] rd_word;
	logic addr_ok;

	// ==========================================================
	// Contact sampling and edge detection
	// Contacts arrive clean and synchronous; one stage aligns them to the decode
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sampled <= '0;
			prev <= '0;
		end
		else
		begin
			sampled <= contact;
			prev <= sampled;
		end
	end

	assign rise = sampled & ~prev;

	// Level and edge per function
	assign lv_cancel = any_term(sampled, codes, FN_CANCEL_OPTIMAL);
	assign lv_motor = any_term(sampled, codes, FN_MOTOR_TWO);
	assign lv_volt1 = any_term(sampled, codes, FN_SRC_VOLT1);
	assign lv_curr = any_term(sampled, codes, FN_SRC_CURR);
	assign lv_volt2 = any_term(sampled, codes, FN_SRC_VOLT2);
	assign lv_stop = any_term(sampled, codes, FN_RAMP_STOP);
	assign lv_up = any_term(sampled, codes, FN_STEP_UP);
	assign lv_down = any_term(sampled, codes, FN_STEP_DOWN);
	assign lv_pid = any_term(sampled, codes, FN_PID_OFF);
	assign lv_clear = any_term(sampled, codes, FN_COUNT_CLEAR);
	assign lv_fwd = any_term(sampled, codes, FN_FWD_INCH);
	assign lv_rev = any_term(sampled, codes, FN_REV_INCH);
	assign lv_fault = any_term(sampled, codes, FN_EMERG_FAULT);
	assign rs_up = any_term(rise, codes, FN_STEP_UP);
	assign rs_down = any_term(rise, codes, FN_STEP_DOWN);
	assign rs_count = any_term(rise, codes, FN_COUNT_INPUT);
	assign rs_stop = any_term(rise, codes, FN_RAMP_STOP);

	assign mode = ctrl[CTRL_MODE_LSB +: 2];
	assign updn_ok = ctrl[CTRL_UPDN_SRC];

	// Inching refused while faulted or ramping to stop; both at once cancel out
	assign inch_fwd = lv_fwd && !lv_rev && fault_state == FLT_NORMAL && !lv_stop;
	assign inch_rev = lv_rev && !lv_fwd && fault_state == FLT_NORMAL && !lv_stop;

	// ==========================================================
	// APB slave: one wait state so every bus output is a flip-flop
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;
	assign fault_reset = wr_done && paddr == OFS_CTRL && pwdata[CTRL_FAULT_RESET];

	always_comb
	begin
		rd_word = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			OFS_CTRL: rd_word = {20'h00000, ctrl};
			OFS_FUNC_LO: rd_word = {codes[3], codes[2], codes[1], codes[0]};
			OFS_FUNC_HI: rd_word = {codes[7], codes[6], codes[5], codes[4]};
			OFS_STEP: rd_word = {16'h0000, step_unit};
			OFS_RATE: rd_word = rate;
			OFS_FREQ: rd_word = {16'h0000, freq};
			OFS_COUNT: rd_word = {16'h0000, count};
			OFS_TARGET: rd_word = {16'h0000, target};
			OFS_EVENT: rd_word = {28'h0000000, events};
			OFS_MASK: rd_word = {28'h0000000, mask};
			OFS_STATE: rd_word = {14'h0000, fault_state, 8'h00, sampled};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus handshake
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && penable && !pready)
		begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr <= !addr_ok;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Configuration registers; the reset request bit is a pulse and never stored
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl <= CTRL_RESET;
			codes <= '0;
			step_unit <= STEP_RESET;
			rate <= RATE_RESET;
			target <= 16'h0000;
			mask <= '0;
		end
		else if (wr_done)
		begin
			case (paddr)
				OFS_CTRL: ctrl <= pwdata[11:0] & ~(12'h001 << CTRL_FAULT_RESET);
				OFS_FUNC_LO: codes[3:0] <= pwdata;
				OFS_FUNC_HI: codes[7:4] <= pwdata;
				OFS_STEP: step_unit <= pwdata[15:0];
				OFS_RATE: rate <= pwdata;
				OFS_TARGET: target <= pwdata[15:0];
				OFS_MASK: mask <= pwdata[EV_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Up/down frequency command
	// A held contact waits out the hold time, then moves once per rate period
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hold_cnt <= 24'h000000;
			rate_cnt <= 24'h000000;
			holding <= 1'b0;
		end
		else if (!(updn_ok && (lv_up ^ lv_down)) || rs_up || rs_down)
		begin
			hold_cnt <= 24'h000000;
			rate_cnt <= 24'h000000;
			holding <= 1'b0;
		end
		else if (!holding)
		begin
			hold_cnt <= hold_cnt + 24'h000001;
			holding <= hold_cnt == 24'(HOLD_CYC - 1);
		end
		else
		begin
			rate_cnt <= (rate_cnt == 24'(RATE_CYC - 1)) ? 24'h000000 :
				rate_cnt + 24'h000001;
		end
	end

	// Software write wins over a terminal move in the same cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
			freq <= 16'h0000;
		else if (wr_done && paddr == OFS_FREQ)
			freq <= pwdata[15:0];
		else if (updn_ok && rs_up && !lv_down)
			freq <= move_freq(freq, step_unit, 1'b1);
		else if (updn_ok && rs_down && !lv_up)
			freq <= move_freq(freq, step_unit, 1'b0);
		else if (holding && rate_cnt == 24'(RATE_CYC - 1))
			freq <= lv_up ? move_freq(freq, rate[15:0], 1'b1) :
				move_freq(freq, rate[31:16], 1'b0);
	end

	// ==========================================================
	// Event counter
	assign count_inc = rs_count && !lv_clear && count != 16'hffff;

	always_ff @(posedge mclk)
	begin
		if (srst)
			count <= 16'h0000;
		else if (lv_clear)
			count <= 16'h0000;
		else if (count_inc)
			count <= count + 16'h0001;
	end

	// ==========================================================
	// Emergency fault sequence
	// Reset is only taken once the terminal is back to normal
	always_ff @(posedge mclk)
	begin
		if (srst)
			fault_state <= FLT_NORMAL;
		else
		begin
			case (fault_state)
				FLT_NORMAL: if (lv_fault) fault_state <= FLT_ACTIVE;
				FLT_ACTIVE: if (!lv_fault) fault_state <= FLT_WAIT_RESET;
				FLT_WAIT_RESET:
				begin
					if (lv_fault)
						fault_state <= FLT_ACTIVE;
					else if (fault_reset)
						fault_state <= FLT_NORMAL;
				end
				default: fault_state <= FLT_NORMAL;
			endcase
		end
	end

	// ==========================================================
	// Sticky events; a read clears only the bits it returned, so an event
	// landing in the wait state is not lost, and a new event beats the clear
	assign new_events[EV_TARGET] = count_inc && (count + 16'h0001) == target;
	assign new_events[EV_FAULT] = lv_fault && fault_state != FLT_ACTIVE;
	assign new_events[EV_RAMP_STOP] = rs_stop;
	assign new_events[EV_INCH] = (inch_fwd || inch_rev) &&
		!(drive_ctrl.forward_inch_command || drive_ctrl.reverse_inch_command);

	always_ff @(posedge mclk)
	begin
		if (srst)
			events <= '0;
		else if (rd_done && paddr == OFS_EVENT)
			events <= (events & ~prdata[EV_W-1:0]) | new_events;
		else
			events <= events | new_events;
	end

	// Interrupt line
	always_ff @(posedge mclk)
	begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(events & mask);
	end

	// ==========================================================
	// Drive control outputs, all registered
	always_ff @(posedge mclk)
	begin
		if (srst)
			drive_ctrl <= '0;
		else
		begin
			// Outside modes 1..4 the optimal ramp is off anyway
			drive_ctrl.auto_ramp <= (mode != 2'b00 || ctrl[3]) &&
				!(ctrl[3] && mode != 2'b00) && !lv_cancel;
			drive_ctrl.motor_set_two <= lv_motor;
			if (lv_volt1 && ctrl[CTRL_EN_VOLT1])
				drive_ctrl.freq_src <= SRC_VOLT1;
			else if (lv_curr && ctrl[CTRL_EN_CURR])
				drive_ctrl.freq_src <= SRC_CURR;
			else if (lv_volt2 && ctrl[CTRL_EN_VOLT2])
				drive_ctrl.freq_src <= SRC_VOLT2;
			else
				drive_ctrl.freq_src <= SRC_PARAM;
			drive_ctrl.ramp_stop <= lv_stop;
			drive_ctrl.coast <= fault_state != FLT_NORMAL || lv_fault;
			drive_ctrl.run_enable <= ctrl[CTRL_RUN] && fault_state == FLT_NORMAL &&
				!lv_fault;
			drive_ctrl.pid_disable <= lv_pid;
			drive_ctrl.forward_inch_command <= inch_fwd;
			drive_ctrl.reverse_inch_command <= inch_rev;
			drive_ctrl.torque_mode <= ctrl[CTRL_TORQUE] && !inch_fwd && !inch_rev;
			drive_ctrl.external_fault_flag <= fault_state != FLT_NORMAL || lv_fault;
			drive_ctrl.emergency_fault_code <= (fault_state != FLT_NORMAL || lv_fault) ?
				FAULT_DISPLAY : 8'h00;
			drive_ctrl.freq_cmd <= freq;
			drive_ctrl.count_value <= lv_clear ? 16'h0000 : count;
			drive_ctrl.count_reached <= target != 16'h0000 && count == target;
		end
	end

endmodule : input_function_decoder

/* tb/input_function_decoder_monitor.sv */
// Port checker for the input function decoder
`timescale 1ns/10ps

module input_function_decoder_monitor
	import input_function_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Terminals and drive outputs
	input wire logic [NUM_TERMS-1:0] contact,
	input drive_ctrl_t drive_ctrl,
	input wire logic irq
);
	// ==========
	// Bus timing
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// Exactly one wait state, then a one-cycle answer
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("apb ready held");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready");

	// ==========
	// Fault, inch and counter relations
	a_fault_code: assert property (drive_ctrl.emergency_fault_code ==
		(drive_ctrl.coast ? FAULT_DISPLAY : 8'h00))
		else $error("fault code wrong");
	a_fault_flag: assert property (drive_ctrl.external_fault_flag == drive_ctrl.coast)
		else $error("fault flag differs");
	a_fault_norun: assert property (drive_ctrl.coast |-> !drive_ctrl.run_enable)
		else $error("run during fault");
	a_inch_speed: assert property (drive_ctrl.forward_inch_command
		|| drive_ctrl.reverse_inch_command |-> !drive_ctrl.torque_mode)
		else $error("torque during inch");
	a_inch_one: assert property (!(drive_ctrl.forward_inch_command
		&& drive_ctrl.reverse_inch_command))
		else $error("both inch");
	// Counter only clears or steps by one; a double count or other jump shows here
	a_count_step: assert property ($changed(drive_ctrl.count_value) |->
		drive_ctrl.count_value == 16'h0000
		|| drive_ctrl.count_value == $past(drive_ctrl.count_value) + 16'h0001)
		else $error("count jumped");
endmodule : input_function_decoder_monitor

bind input_function_decoder input_function_decoder_monitor u_mon (.mclk(mclk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .contact(contact),
	.drive_ctrl(drive_ctrl), .irq(irq));

/* tb/contact_model.sv */
// Behavioural model of the switch contacts on the drive terminals
`timescale 1ns/10ps

module contact_model
(
	// Clock
	input wire logic mclk,
	// Commanded and actual contact levels
	input wire logic [7:0] want,
	output logic [7:0] contact
);
	// ==========
	// Contacts move just after an edge, never mid-cycle
	initial contact = 8'h00;
	always @(posedge mclk)
		contact <= want;
endmodule : contact_model

/* tb/input_function_decoder_tb.sv */
// Self-checking testbench for the input function decoder
`timescale 1ns/10ps

module input_function_decoder_tb
	import input_function_pkg::*;
;
	// ==========
	// Stimulus and observed signals
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] want = 8'h00;
	logic [NUM_TERMS-1:0] contact;
	drive_ctrl_t dc;
	logic irq;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int n_checks = 0;

	always #25 mclk = ~mclk;

	// Short hold and rate counts keep the run brief
	input_function_decoder #(.HOLD_CYC(8), .RATE_CYC(4)) u_dut (.mclk(mclk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .contact(contact),
		.drive_ctrl(dc), .irq(irq));
	contact_model u_sw (.mclk(mclk), .want(want), .contact(contact));

	// ==========
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic chkb(input string what, input logic seen, input logic exp);
		chk(what, {31'h0, seen}, {31'h0, exp});
	endtask : chkb

	// One APB transfer; waits on pready, the watchdog bounds a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Set contacts and let the two-stage decode settle
	task automatic sw(input logic [7:0] c);
		@(posedge mclk);
		want <= c;
		repeat (6) @(posedge mclk);
	endtask : sw

	// ==========
	// Scenarios
	task automatic t_regs;
		apb(1'b0, OFS_STEP, 32'h0);
		chk("step reset", rd, {16'h0, STEP_RESET});
		apb(1'b0, OFS_RATE, 32'h0);
		chk("rate reset", rd, RATE_RESET);
		apb(1'b1, 12'h0fc, 32'h0);
		chkb("unmapped", err, 1'b1);
	endtask : t_regs

	task automatic t_levels;
		apb(1'b1, OFS_FUNC_LO, {FN_FWD_INCH, FN_PID_OFF, FN_RAMP_STOP, FN_MOTOR_TWO});
		apb(1'b1, OFS_FUNC_HI, {16'h0, FN_REV_INCH, FN_CANCEL_OPTIMAL});
		apb(1'b1, OFS_CTRL, 32'h13);
		sw(8'h00);
		chkb("auto ramp", dc.auto_ramp, 1'b1);
		sw(8'h10);
		chkb("linear", dc.auto_ramp, 1'b0);
		sw(8'h01);
		chkb("motor two", dc.motor_set_two, 1'b1);
		sw(8'h04);
		chkb("pid off", dc.pid_disable, 1'b1);
		sw(8'h08);
		chkb("fwd inch", dc.forward_inch_command, 1'b1);
		chkb("inch speed", dc.torque_mode, 1'b0);
		sw(8'h00);
		chkb("torque back", dc.torque_mode, 1'b1);
		sw(8'h20);
		chkb("rev inch", dc.reverse_inch_command, 1'b1);
		sw(8'h02);
		chkb("ramp stop", dc.ramp_stop, 1'b1);
	endtask : t_levels

	task automatic t_src;
		freq_src_t e;
		apb(1'b1, OFS_FUNC_LO, {FN_SRC_VOLT2, FN_SRC_CURR, FN_SRC_VOLT1, 8'h00});
		apb(1'b1, OFS_CTRL, 32'h701);
		for (int i = 0; i < 8; i++)
		begin
			sw(8'(i << 1));
			e = i[0] ? SRC_VOLT1 : i[1] ? SRC_CURR : i[2] ? SRC_VOLT2 : SRC_PARAM;
			chk("source", {30'h0, dc.freq_src}, {30'h0, e});
		end
		chkb("mode off", dc.auto_ramp, 1'b0);
	endtask : t_src

	task automatic t_fault;
		apb(1'b1, OFS_FUNC_LO, {24'h0, FN_EMERG_FAULT});
		apb(1'b1, OFS_MASK, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		sw(8'h01);
		chkb("coast", dc.coast, 1'b1);
		chk("fault code", dc.emergency_fault_code, {24'h0, FAULT_DISPLAY});
		chkb("fault flag", dc.external_fault_flag, 1'b1);
		chkb("masked", irq, 1'b0);
		apb(1'b1, OFS_MASK, 32'h2);
		repeat (3) @(posedge mclk);
		chkb("irq", irq, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h21);
		sw(8'h00);
		chkb("wait reset", dc.coast, 1'b1);
		chkb("no run", dc.run_enable, 1'b0);
		apb(1'b0, OFS_EVENT, 32'h0);
		chk("event", rd & 32'h2, 32'h2);
		repeat (3) @(posedge mclk);
		chkb("irq clear", irq, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h21);
		repeat (4) @(posedge mclk);
		chkb("coast off", dc.coast, 1'b0);
		chkb("run", dc.run_enable, 1'b1);
		chk("code off", dc.emergency_fault_code, 32'h0);
	endtask : t_fault

	task automatic t_step;
		int d;
		apb(1'b1, OFS_FUNC_LO, {16'h0, FN_STEP_DOWN, FN_STEP_UP});
		apb(1'b1, OFS_FREQ, 32'h64);
		apb(1'b1, OFS_STEP, 32'h5);
		apb(1'b1, OFS_RATE, 32'h0003_0002);
		sw(8'h01);
		sw(8'h00);
		chk("up refused", dc.freq_cmd, 32'h64);
		apb(1'b1, OFS_CTRL, 32'h801);
		sw(8'h01);
		sw(8'h00);
		chk("step up", dc.freq_cmd, 32'h69);
		sw(8'h02);
		sw(8'h00);
		chk("step down", dc.freq_cmd, 32'h64);
		want <= 8'h01;
		repeat (40) @(posedge mclk);
		sw(8'h00);
		d = int'(dc.freq_cmd) - 105;
		chkb("held up", d >= 10 && d <= 20 && d % 2 == 0, 1'b1);
	endtask : t_step

	task automatic t_count;
		apb(1'b1, OFS_FUNC_LO, {16'h0, FN_COUNT_CLEAR, FN_COUNT_INPUT});
		apb(1'b1, OFS_TARGET, 32'h3);
		apb(1'b1, OFS_MASK, 32'h1);
		repeat (2)
		begin
			sw(8'h01);
			sw(8'h00);
		end
		chkb("not reached", dc.count_reached, 1'b0);
		sw(8'h01);
		repeat (10) @(posedge mclk);
		chk("count", dc.count_value, 32'h3);
		chkb("reached", dc.count_reached, 1'b1);
		chkb("target irq", irq, 1'b1);
		sw(8'h03);
		sw(8'h02);
		sw(8'h03);
		chk("cleared", dc.count_value, 32'h0);
		sw(8'h00);
		sw(8'h01);
		chk("resumed", dc.count_value, 32'h1);
	endtask : t_count

	// ==========
	// Verdict, sequence and watchdog
	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		t_regs();
		t_levels();
		t_src();
		t_fault();
		t_step();
		t_count();
		close_out();
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		close_out();
	end
endmodule : input_function_decoder_tb
